// *** core/pef_defines.svh ***
/*
 Constants for the port E low pin function select block: register offsets,
 field positions, reset values. Assumes inclusion by bare name.
*/
`ifndef PEF_DEFINES_SVH
`define PEF_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define PEF_ADDR_W 4
`define PEF_OFS_CTRL2 4'h0
`define PEF_OFS_PORTD_DATA 4'h2
`define PEF_RDATA_UNMAPPED 16'h0000

// ****************************************
// Field positions
// ****************************************
`define PEF_POS_PIN7 14
`define PEF_POS_PIN6 12
`define PEF_POS_PIN5 10
`define PEF_POS_PIN4 8
`define PEF_POS_PIN3 6
`define PEF_POS_PIN2 4
`define PEF_POS_PIN1 2
`define PEF_POS_PIN0 0

// ****************************************
// Reset values and masks
// ****************************************
`define PEF_CTRL2_RST_NORMAL 16'h0040
`define PEF_CTRL2_RST_HOSTBOOT 16'h5555
`define PEF_CTRL2_WMASK 16'h777f
`define PEF_PORTD_RST 8'h00

`endif

// *** core/pef_pkg.sv ***
/*
 Types for the port E low pin function select block.
 Assumes nothing beyond the compile order.
*/
package pef_pkg;
   typedef enum logic [1:0] {
      PEF_FN_PORT,
      PEF_FN_HOST,
      PEF_FN_SERIAL,
      PEF_FN_BAD
   } pef_func_t;
endpackage

// *** core/pef_pin_mux.sv ***
/*
 Pin function select for port E pins 0..7 plus the output OR on
 port D pins 2, 4 and 5.
 Assumes a synchronous register port, boot mode strap steady at reset
 release, and peripherals that supply out/oe and take in per pin.
*/
`timescale 1ns/1ns
`include "pef_defines.svh"

module pef_pin_mux
   import pef_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic host_boot_mode,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] pe_in,
   output logic [7:0] pe_out,
   output logic [7:0] pe_oe,
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe,
   output logic [7:0] port_in,
   input wire logic [7:0] host_out,
   input wire logic [7:0] host_oe,
   output logic [7:0] host_in,
   input wire logic [7:0] serial_out,
   input wire logic [7:0] serial_oe,
   output logic [7:0] serial_in,
   input wire logic [7:0] pd_in,
   input wire logic [7:0] pd_alt_out,
   input wire logic [7:0] pd_alt_oe,
   output logic [7:0] pd_out,
   output logic [7:0] pd_oe,
   output logic [7:0] pd_alt_in
);

   // ****************************************
   // Reset synchroniser and boot strap
   // ****************************************
   logic rst_meta;
   logic rst_n;
   logic strap_done;
   logic [15:0] ctrl;
   logic [7:0] pd_data;
   pef_func_t sel [8];

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************
   // Control register, port D data register and read port
   // ****************************************
   // Strap loaded on third clock after nrst release (first clock after synchronised rst_n rises)
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
         ctrl <= `PEF_CTRL2_RST_NORMAL;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         ctrl <= host_boot_mode ? `PEF_CTRL2_RST_HOSTBOOT : `PEF_CTRL2_RST_NORMAL;
      end else if (reg_wr && reg_addr == `PEF_OFS_CTRL2) begin
         ctrl <= reg_wdata & `PEF_CTRL2_WMASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pd_data <= `PEF_PORTD_RST;
      end else if (reg_wr && reg_addr == `PEF_OFS_PORTD_DATA) begin
         pd_data <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else if (reg_addr == `PEF_OFS_CTRL2) begin
         reg_rdata <= ctrl;
      end else if (reg_addr == `PEF_OFS_PORTD_DATA) begin
         reg_rdata <= {8'h00, pd_data};
      end else begin
         reg_rdata <= `PEF_RDATA_UNMAPPED;
      end
   end

   // ****************************************
   // Field decode
   // ****************************************
   function automatic pef_func_t decode2(input logic [1:0] f);
      case (f)
         2'h0: decode2 = PEF_FN_PORT;
         2'h1: decode2 = PEF_FN_HOST;
         2'h2: decode2 = PEF_FN_SERIAL;
         default: decode2 = PEF_FN_BAD;
      endcase
   endfunction

   always_comb begin
      sel[0] = decode2(ctrl[`PEF_POS_PIN0 +: 2]);
      sel[1] = decode2(ctrl[`PEF_POS_PIN1 +: 2]);
      sel[2] = decode2(ctrl[`PEF_POS_PIN2 +: 2]);
      sel[3] = decode2({1'b0, ctrl[`PEF_POS_PIN3]});
      sel[4] = decode2(ctrl[`PEF_POS_PIN4 +: 2]);
      sel[5] = decode2({1'b0, ctrl[`PEF_POS_PIN5]});
      sel[6] = decode2(ctrl[`PEF_POS_PIN6 +: 2]);
      sel[7] = decode2({1'b0, ctrl[`PEF_POS_PIN7]});
   end

   // ****************************************
   // Port E pin mux
   // ****************************************
   // Prohibited code leaves the pin undriven
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pe
         always_comb begin
            pe_out[i] = 1'b0;
            pe_oe[i] = 1'b0;
            case (sel[i])
               PEF_FN_PORT: begin
                  pe_out[i] = port_out[i];
                  pe_oe[i] = port_oe[i];
               end
               PEF_FN_HOST: begin
                  pe_out[i] = host_out[i];
                  pe_oe[i] = host_oe[i];
               end
               PEF_FN_SERIAL: begin
                  pe_out[i] = serial_out[i];
                  pe_oe[i] = serial_oe[i];
               end
               default: begin
                  pe_out[i] = 1'b0;
                  pe_oe[i] = 1'b0;
               end
            endcase
         end
         assign port_in[i] = (sel[i] == PEF_FN_PORT) ? pe_in[i] : 1'b0;
         assign host_in[i] = (sel[i] == PEF_FN_HOST) ? pe_in[i] : 1'b0;
         assign serial_in[i] = (sel[i] == PEF_FN_SERIAL) ? pe_in[i] : 1'b0;
      end
   endgenerate

   // ****************************************
   // Port D restricted pins
   // ****************************************
   localparam logic [7:0] PD_OR_PINS = 8'h34;

   always_comb begin
      pd_out = pd_alt_out | (pd_data & PD_OR_PINS);
      pd_oe = pd_alt_oe;
      pd_alt_in = pd_in;
   end

   // ****************************************
   // Checks
   // ****************************************
   reserved_zero_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == `PEF_OFS_CTRL2 |=> reg_rdata[15] == 1'b0 &&
         reg_rdata[11] == 1'b0 && reg_rdata[7] == 1'b0)
      else $error("reserved control bit read as one");

   ctrl_readback_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      strap_done && reg_wr && reg_addr == `PEF_OFS_CTRL2 ##1 reg_rd &&
         reg_addr == `PEF_OFS_CTRL2 && !reg_wr
      |=> reg_rdata == ($past(reg_wdata, 2) & `PEF_CTRL2_WMASK))
      else $error("control register readback mismatch");

   boot_reset_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rst_n && !strap_done |=> ctrl == ($past(host_boot_mode) ?
         `PEF_CTRL2_RST_HOSTBOOT : `PEF_CTRL2_RST_NORMAL))
      else $error("boot mode reset value wrong");

   pin7_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[14] |-> pe_out[7] == host_out[7] && pe_oe[7] == host_oe[7] && !port_in[7])
      else $error("pin 7 host select wrong");

   pin6_serial_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[13:12] == 2'h2 |-> pe_out[6] == serial_out[6] && serial_in[6] == pe_in[6])
      else $error("pin 6 serial select wrong");

   pin5_port_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ctrl[10] |-> pe_oe[5] == port_oe[5] && port_in[5] == pe_in[5])
      else $error("pin 5 port select wrong");

   pin4_serial_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[9:8] == 2'h2 |-> pe_oe[4] == serial_oe[4] && !host_in[4])
      else $error("pin 4 serial select wrong");

   pin3_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[6] |-> host_in[3] == pe_in[3] && pe_oe[3] == host_oe[3])
      else $error("pin 3 host select wrong");

   pin2_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[5:4] == 2'h1 |-> pe_out[2] == host_out[2] && pe_oe[2] == host_oe[2])
      else $error("pin 2 host select wrong");

   pin1_bad_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[3:2] == 2'h3 |-> !pe_oe[1] && !port_in[1] && !serial_in[1])
      else $error("pin 1 prohibited code drives");

   pin0_serial_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[1:0] == 2'h2 |-> pe_out[0] == serial_out[0] && pe_oe[0] == serial_oe[0])
      else $error("pin 0 serial select wrong");

   pd_or_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pd_data[4] |-> pd_out[4] && pd_out[3] == pd_alt_out[3])
      else $error("port D output OR wrong");

   pd_input_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pd_alt_in == pd_in)
      else $error("port D input altered");

   // ****************************************
   // Read port, control register and port D checks
   // ****************************************
   rdata_idle_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not cleared after read cycle");

   rdata_pd_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == `PEF_OFS_PORTD_DATA |=> reg_rdata == {8'h00, $past(pd_data)})
      else $error("port D data readback wrong");

   ctrl_reserved_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ctrl[15] && !ctrl[11] && !ctrl[7])
      else $error("reserved control bit stored");

   pin3_reset_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rst_n && !strap_done |=> ctrl[6])
      else $error("pin 3 select not set after reset");

   pd_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pd_data[2] && pd_data[5] |-> pd_out[2] && pd_out[5])
      else $error("port D data bit not forcing output high");

   pd_pass_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !pd_data[4] |-> pd_out[4] == pd_alt_out[4] && pd_oe == pd_alt_oe)
      else $error("port D output changed with data bit clear");

   pd_other_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pd_out[1:0] == pd_alt_out[1:0] && pd_out[3] == pd_alt_out[3] &&
         pd_out[7:6] == pd_alt_out[7:6])
      else $error("unrestricted port D pin altered");

   // ****************************************
   // Further pin select checks
   // ****************************************
   pin7_port_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ctrl[14] |-> pe_out[7] == port_out[7] && port_in[7] == pe_in[7] && !host_in[7])
      else $error("pin 7 port select wrong");

   pin6_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[13:12] == 2'h1 |-> pe_oe[6] == host_oe[6] && host_in[6] == pe_in[6] && !serial_in[6])
      else $error("pin 6 host select wrong");

   pin6_bad_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[13:12] == 2'h3 |-> !pe_oe[6] && !port_in[6] && !host_in[6] && !serial_in[6])
      else $error("pin 6 prohibited code drives");

   pin5_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[10] |-> pe_out[5] == host_out[5] && pe_oe[5] == host_oe[5] && host_in[5] == pe_in[5])
      else $error("pin 5 host select wrong");

   pin4_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[9:8] == 2'h1 |-> host_in[4] == pe_in[4] && pe_oe[4] == host_oe[4] && !port_in[4])
      else $error("pin 4 host select wrong");

   pin4_bad_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[9:8] == 2'h3 |-> !pe_oe[4] && !port_in[4] && !serial_in[4])
      else $error("pin 4 prohibited code drives");

   pin3_port_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ctrl[6] |-> pe_oe[3] == port_oe[3] && port_in[3] == pe_in[3] && !host_in[3])
      else $error("pin 3 port select wrong");

   pin2_serial_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[5:4] == 2'h2 |-> serial_in[2] == pe_in[2] && pe_oe[2] == serial_oe[2] &&
         !port_in[2])
      else $error("pin 2 serial select wrong");

   pin2_bad_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[5:4] == 2'h3 |-> !pe_oe[2] && !host_in[2] && !serial_in[2])
      else $error("pin 2 prohibited code drives");

   pin1_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[3:2] == 2'h1 |-> pe_out[1] == host_out[1] && pe_oe[1] == host_oe[1])
      else $error("pin 1 host select wrong");

   pin0_host_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[1:0] == 2'h1 |-> host_in[0] == pe_in[0] && pe_oe[0] == host_oe[0])
      else $error("pin 0 host select wrong");

   pin0_bad_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl[1:0] == 2'h3 |-> !pe_oe[0] && !port_in[0] && !host_in[0])
      else $error("pin 0 prohibited code drives");

endmodule

// *** test/tb_pef_pin_mux.sv ***
/*
 Self-checking bench for the port E low pin function select block.
 Assumes the design compiled first and core/ on the include path.
*/
`timescale 1ns/1ns
`include "pef_defines.svh"

module tb_pef_pin_mux;
   logic clk_sys, nrst, host_boot_mode, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [7:0] pe_in, pe_out, pe_oe, port_out, port_oe, port_in;
   logic [7:0] host_out, host_oe, host_in, serial_out, serial_oe, serial_in;
   logic [7:0] pd_in, pd_alt_out, pd_alt_oe, pd_out, pd_oe, pd_alt_in;
   logic [15:0] tab [5] = '{16'h0000, 16'h5555, 16'h222a, 16'hffff, 16'h1261};
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   pef_pin_mux pef_pin_mux_inst (
      .clk_sys(clk_sys), .nrst(nrst), .host_boot_mode(host_boot_mode),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
      .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
      .host_out(host_out), .host_oe(host_oe), .host_in(host_in),
      .serial_out(serial_out), .serial_oe(serial_oe), .serial_in(serial_in),
      .pd_in(pd_in), .pd_alt_out(pd_alt_out), .pd_alt_oe(pd_alt_oe),
      .pd_out(pd_out), .pd_oe(pd_oe), .pd_alt_in(pd_alt_in)
   );

   // ****************************************
   // Helpers
   // ****************************************
   task automatic finish_test;
      $display("TB: checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(name, exp, reg_rdata);
      @(posedge clk_sys);
   endtask

   // Expected mux result per pin from a control value
   task automatic chk_pins(input logic [15:0] c);
      logic [7:0] eo, eout, ep, eh, es;
      logic [1:0] s;
      logic [3:0] t;
      @(negedge clk_sys);
      for (int p = 0; p < 8; p++) begin
         s = c[2*p +: 2];
         t = {1'b0, serial_oe[p], host_oe[p], port_oe[p]};
         eo[p] = t[s];
         t = {1'b0, serial_out[p], host_out[p], port_out[p]};
         eout[p] = t[s];
         ep[p] = (s == 2'h0) & pe_in[p];
         eh[p] = (s == 2'h1) & pe_in[p];
         es[p] = (s == 2'h2) & pe_in[p];
      end
      chk("pe_oe", {8'h00, eo}, {8'h00, pe_oe});
      chk("pe_out", {8'h00, eout}, {8'h00, pe_out});
      chk("port_in", {8'h00, ep}, {8'h00, port_in});
      chk("host_in", {8'h00, eh}, {8'h00, host_in});
      chk("serial_in", {8'h00, es}, {8'h00, serial_in});
      @(posedge clk_sys);
   endtask

   task automatic chk_pd(input logic [7:0] dr);
      @(negedge clk_sys);
      chk("pd_out", {8'h00, pd_alt_out | (dr & 8'h34)}, {8'h00, pd_out});
      chk("pd_oe", {8'h00, pd_alt_oe}, {8'h00, pd_oe});
      chk("pd_alt_in", {8'h00, pd_in}, {8'h00, pd_alt_in});
      @(posedge clk_sys);
   endtask

   task automatic do_reset(input logic boot);
      nrst <= 1'b0;
      host_boot_mode <= boot;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
   endtask

   // ****************************************
   // Clock and timeout
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         finish_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      host_boot_mode = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      pe_in = 8'h5a;
      port_out = 8'ha5;
      port_oe = 8'h0f;
      host_out = 8'h3c;
      host_oe = 8'hf0;
      serial_out = 8'h96;
      serial_oe = 8'h33;
      pd_in = 8'h6c;
      pd_alt_out = 8'h81;
      pd_alt_oe = 8'h5a;
      do_reset(1'b0);
      rd(`PEF_OFS_CTRL2, 16'h0040, "ctrl_reset");
      chk_pins(16'h0040);
      rd(4'h5, 16'h0000, "unmapped_rd");
      wr(4'h5, 16'hffff);
      rd(`PEF_OFS_CTRL2, 16'h0040, "ctrl_unmapped_wr");
      for (int i = 0; i < 5; i++) begin
         wr(`PEF_OFS_CTRL2, tab[i]);
         rd(`PEF_OFS_CTRL2, tab[i] & 16'h777f, "ctrl");
         chk_pins(tab[i] & 16'h777f);
      end
      wr(`PEF_OFS_PORTD_DATA, 16'h00cb);
      chk_pd(8'hcb);
      rd(`PEF_OFS_PORTD_DATA, 16'h00cb, "pd_data");
      wr(`PEF_OFS_PORTD_DATA, 16'h00ff);
      chk_pd(8'hff);
      wr(`PEF_OFS_PORTD_DATA, 16'h0000);
      chk_pd(8'h00);
      do_reset(1'b1);
      rd(`PEF_OFS_CTRL2, 16'h5555, "ctrl_hostboot");
      chk_pins(16'h5555);
      finish_test();
   end
endmodule
